/* psr_defines.vh */
// Constants for the pipelined read slave port
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH

// Data path and address widths
`define PSR_DATA_W 32
`define PSR_LANES 4
`define PSR_ADDR_W 8
`define PSR_MEM_DEPTH 256

// Outstanding-read tracking
`define PSR_MAX_PEND 3'h4
`define PSR_CNT_W 3
`define PSR_PTR_W 2
`define PSR_QUEUE_DEPTH 4

// Latency handling, fixed read latency in cycles (must be 2 or more)
`define PSR_FIX_LAT 3'h2
`define PSR_VAR_BASE 3'h1
`define PSR_THR_W 3
`define PSR_TICK_W 8

// Queue entry layout: {threshold, stamp, data}
`define PSR_ENT_W 43
`define PSR_ENT_DATA_LSB 0
`define PSR_ENT_STAMP_LSB 32
`define PSR_ENT_THR_LSB 40

`endif

/* psr_fabric_model.sv */
// Fabric model: requests out, returns in
`timescale 1ns/10ps
`default_nettype none
module psr_fabric_model (
  // Answer in, request out
  input wire logic SYS_CLK, STALL_REQUEST, READ_WORD_VALID,
  input wire logic [31:0] READ_WORD,
  output wire logic CHIP_SELECT, READ, WRITE, LATENCY_MODE,
  output wire logic [7:0] ADDRESS,
  output wire logic [31:0] WRITE_WORD,
  output wire logic [3:0] LANE_ENABLES
);
  logic [47:0] q_reg = '0;
  logic [31:0] got[$];
  assign {CHIP_SELECT, READ, WRITE, LATENCY_MODE, ADDRESS, WRITE_WORD, LANE_ENABLES} = q_reg;
  // Collect returned words
  always @(posedge SYS_CLK) if (READ_WORD_VALID) got.push_back(READ_WORD);
  // One request, held through wait-states
  task req(logic w, m, logic [7:0] a, logic [31:0] d, logic [3:0] be);
    @(negedge SYS_CLK);
    q_reg = {1'b1, !w, w, m, a, d, be};
    while (STALL_REQUEST) @(negedge SYS_CLK);
  endtask
  // Release, select and strobes drop, other lines invert their last value
  task idle;
    @(negedge SYS_CLK);
    q_reg = {3'h0, ~q_reg[44:0]};
  endtask
endmodule // psr_fabric_model
`default_nettype wire

/* psr_pend_queue.v */
// Ordered queue of pending read results
`timescale 1ns/10ps
`default_nettype none
`include "psr_defines.vh"

module psr_pend_queue (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Fill side
  input wire push,
  input wire [`PSR_ENT_W-1:0] push_data,
  // Drain side
  input wire pop,
  output wire [`PSR_ENT_W-1:0] head_data,
  output wire head_valid,
  // Occupancy
  output reg [`PSR_CNT_W-1:0] count_reg
);

  reg [`PSR_ENT_W-1:0] slots [0:`PSR_QUEUE_DEPTH-1];
  reg [`PSR_PTR_W-1:0] wr_ptr_reg;
  reg [`PSR_PTR_W-1:0] rd_ptr_reg;

  // Head entry and its presence
  assign head_data = slots[rd_ptr_reg];
  assign head_valid = (count_reg != {`PSR_CNT_W{1'b0}});

  // Pointers and occupancy, entries leave in arrival order
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= {`PSR_PTR_W{1'b0}};
      rd_ptr_reg <= {`PSR_PTR_W{1'b0}};
      count_reg <= {`PSR_CNT_W{1'b0}};
    end else begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 2'h1;
      if (pop && head_valid)
        rd_ptr_reg <= rd_ptr_reg + 2'h1;
      count_reg <= count_reg + {2'h0, push} - {2'h0, pop && head_valid};
    end
  end

  // Slot storage
  always @(posedge clk) begin
    if (push)
      slots[wr_ptr_reg] <= push_data;
  end

endmodule // psr_pend_queue
`default_nettype wire

/* psr_read_port.v */
// Pipelined memory-mapped slave port with fixed or variable read latency
`timescale 1ns/10ps
`default_nettype none
`include "psr_defines.vh"

// Functional notes
// - A write completes on the first edge where stall_request is low.
// - No setup or hold phases; requests are taken in a single edge.
// - Writes are never pipelined; each completes on its own edge.
// - New read addresses are taken while earlier reads are still pending.
// - Without stalls one request is accepted every clock cycle.
// - The address is latched on the final edge of the address phase.
// - A read's data never appears during its own address phase.
// - Fixed mode returns data on the Nth edge after the address phase.
// - Fixed-latency mode uses the plain read signal set and timing only.
// - The read_word_valid output marks this as a variable-latency port.
// - Read data and its valid strobe stand together for one cycle.
// - Read results return strictly in accepted order.
// - Variable mode returns data at least one cycle after the address phase.
// - Stall is raised while outstanding reads reach the design maximum.
// - Writes during pending reads are held off if they cannot be served.
// - No setup, hold, fixed wait-states or tristate operation are used.
module psr_read_port (
  // Clock and reset
  input wire SYS_CLK,
  input wire RST,
  // Request from the fabric
  input wire CHIP_SELECT,
  input wire READ,
  input wire WRITE,
  input wire [`PSR_ADDR_W-1:0] ADDRESS,
  input wire [`PSR_DATA_W-1:0] WRITE_WORD,
  input wire [`PSR_LANES-1:0] LANE_ENABLES,
  // Latency mode, high selects variable latency
  input wire LATENCY_MODE,
  // Answer to the fabric
  output reg STALL_REQUEST,
  output reg [`PSR_DATA_W-1:0] READ_WORD,
  output reg READ_WORD_VALID
);

  // Word store, written by lanes and read at acceptance
  reg [`PSR_DATA_W-1:0] mem [0:`PSR_MEM_DEPTH-1];

  // Free-running age reference
  reg [`PSR_TICK_W-1:0] tick_reg;
  reg [`PSR_TICK_W-1:0] tick_next;

  // Next values of the answer registers
  reg stall_next;
  reg [`PSR_DATA_W-1:0] read_word_next;
  reg read_word_valid_next;

  // Write path
  wire [`PSR_DATA_W-1:0] write_merged;

  // Acceptance strobes
  wire accept_rd;
  wire accept_wr;

  // Pending-read queue traffic
  wire [`PSR_ENT_W-1:0] push_entry;
  wire [`PSR_ENT_W-1:0] head_entry;
  wire head_valid;
  wire [`PSR_CNT_W-1:0] pend_count;

  // Head entry fields and the return decision
  wire [`PSR_THR_W-1:0] head_thr;
  wire [`PSR_TICK_W-1:0] head_stamp;
  wire [`PSR_DATA_W-1:0] head_word;
  wire [`PSR_TICK_W-1:0] head_age;
  wire ret;
  wire [`PSR_CNT_W-1:0] cnt_next;

  // Edge count at which a read result may be loaded out
  function [`PSR_THR_W-1:0] ret_threshold;
    input [`PSR_ADDR_W-1:0] addr;
    input var_mode;
    begin
      if (var_mode)
        ret_threshold = {1'b0, addr[1:0]} + `PSR_VAR_BASE;
      else
        ret_threshold = `PSR_FIX_LAT - 3'h1;
    end
  endfunction

  // Request decode: selected, of the wanted kind, and not stalled
  function req_taken;
    input sel;
    input kind;
    input stall;
    begin
      req_taken = sel & kind & ~stall;
    end
  endfunction

  // Occupancy after one edge, given an entry in and an entry out
  function [`PSR_CNT_W-1:0] count_step;
    input [`PSR_CNT_W-1:0] count;
    input add_one;
    input take_one;
    begin
      count_step = count + {2'h0, add_one} - {2'h0, take_one};
    end
  endfunction

  // Cycles elapsed since a stamp, correct across counter wrap
  function [`PSR_TICK_W-1:0] age_since;
    input [`PSR_TICK_W-1:0] now;
    input [`PSR_TICK_W-1:0] stamp;
    begin
      age_since = now - stamp;
    end
  endfunction

  // Enabled byte lanes of new data laid over a stored word
  function [`PSR_DATA_W-1:0] lane_merge;
    input [`PSR_DATA_W-1:0] old_word;
    input [`PSR_DATA_W-1:0] new_word;
    input [`PSR_LANES-1:0] lanes;
    integer i;
    begin
      lane_merge = old_word;
      for (i = 0; i < `PSR_LANES; i = i + 1) begin
        if (lanes[i])
          lane_merge[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
  endfunction

  // Queue entry assembly: return threshold, age stamp, captured word
  function [`PSR_ENT_W-1:0] pack_entry;
    input [`PSR_THR_W-1:0] thr;
    input [`PSR_TICK_W-1:0] stamp;
    input [`PSR_DATA_W-1:0] word;
    begin
      pack_entry = {thr, stamp, word};
    end
  endfunction

  // Request acceptance in a single edge, read wins over a stray write
  assign accept_rd = req_taken(CHIP_SELECT, READ, STALL_REQUEST);
  assign accept_wr = req_taken(CHIP_SELECT, WRITE & ~READ, STALL_REQUEST);

  // Data captured at acceptance travels with its age stamp
  assign push_entry = pack_entry(ret_threshold(ADDRESS, LATENCY_MODE), tick_reg, mem[ADDRESS]);

  // Queue of pending reads, several in flight at once
  psr_pend_queue u_pend (
    .clk(SYS_CLK),
    .rst(RST),
    .push(accept_rd),
    .push_data(push_entry),
    .pop(ret),
    .head_data(head_entry),
    .head_valid(head_valid),
    .count_reg(pend_count)
  );

  // Head entry fields and its age in cycles
  assign head_word = head_entry[`PSR_ENT_STAMP_LSB-1:`PSR_ENT_DATA_LSB];
  assign head_stamp = head_entry[`PSR_ENT_THR_LSB-1:`PSR_ENT_STAMP_LSB];
  assign head_thr = head_entry[`PSR_ENT_W-1:`PSR_ENT_THR_LSB];
  assign head_age = age_since(tick_reg, head_stamp);

  // Only the oldest entry may return, once old enough
  assign ret = head_valid && (head_age >= {5'h00, head_thr});

  // Outstanding count after this edge
  assign cnt_next = count_step(pend_count, accept_rd, ret);

  // Stored word with the enabled lanes replaced
  assign write_merged = lane_merge(mem[ADDRESS], WRITE_WORD, LANE_ENABLES);

  // Next values of the age reference and the answer registers
  always @* begin
    tick_next = tick_reg + 8'h01;
    stall_next = (cnt_next >= `PSR_MAX_PEND);
    if (ret) begin
      read_word_next = head_word;
      read_word_valid_next = 1'b1;
    end else begin
      read_word_next = {`PSR_DATA_W{1'b0}};
      read_word_valid_next = 1'b0;
    end
  end

  // Free-running age reference
  always @(posedge SYS_CLK) begin
    if (RST)
      tick_reg <= {`PSR_TICK_W{1'b0}};
    else
      tick_reg <= tick_next;
  end

  // Stall only when the pending limit is reached, held high in reset
  always @(posedge SYS_CLK) begin
    if (RST)
      STALL_REQUEST <= 1'b1;
    else
      STALL_REQUEST <= stall_next;
  end

  // Read result and its valid strobe, one cycle each
  always @(posedge SYS_CLK) begin
    if (RST) begin
      READ_WORD <= {`PSR_DATA_W{1'b0}};
      READ_WORD_VALID <= 1'b0;
    end else begin
      READ_WORD <= read_word_next;
      READ_WORD_VALID <= read_word_valid_next;
    end
  end

  // Byte-lane writes, served even with reads pending; a pending read of the
  // same word keeps the value captured at its acceptance
  always @(posedge SYS_CLK) begin
    if (accept_wr)
      mem[ADDRESS] <= write_merged;
  end

endmodule // psr_read_port
`default_nettype wire

/* psr_read_port_checker.sv */
// Pin assertions for the read port
`timescale 1ns/10ps
`default_nettype none
module psr_read_port_checker (
  // Pins watched
  input wire logic SYS_CLK, RST, CHIP_SELECT, READ, LATENCY_MODE,
  input wire logic STALL_REQUEST, READ_WORD_VALID,
  input wire logic [31:0] READ_WORD
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic [2:0] p_reg;
  wire v = READ_WORD_VALID;
  wire s = STALL_REQUEST;
  wire acc = CHIP_SELECT & READ & !s;
  wire a0 = acc & p_reg == 3'h0;
  // Reads the port itself still holds: a return now on the pins has left it
  wire [2:0] dpend = p_reg - 3'(v);
  // Outstanding reads, so latency is judged only on an empty pipe
  always @(posedge SYS_CLK) p_reg <= RST ? 3'h0 : p_reg + 3'(acc) - 3'(v);
  AST_ZERO: assert property (!v |-> READ_WORD == 0) else $error("stray data");
  AST_FIX: assert property (a0 & !LATENCY_MODE |-> ##2 v) else $error("fixed latency");
  AST_GAP: assert property (a0 |=> !v ##[1:4] v) else $error("latency");
  AST_FULL: assert property (dpend == 3'h4 |-> s) else $error("no stall");
  AST_OPEN: assert property (dpend < 3'h4 & !$past(RST) |-> !s) else $error("stall");
  AST_RST: assert property ($past(RST) |-> !v) else $error("reset");
  AST_MAX: assert property (p_reg <= 3'h4) else $error("overrun");
  AST_ORD: assert property (v |-> p_reg != 3'h0) else $error("extra");
endmodule // psr_read_port_checker
bind psr_read_port psr_read_port_checker u_chk (.*);
`default_nettype wire

/* psr_read_port_tb_top.sv */
// Self-checking bench for the read port
`timescale 1ns/10ps
`default_nettype none
module psr_read_port_tb_top;
  logic SYS_CLK = 0, RST = 1, CHIP_SELECT, READ, WRITE, LATENCY_MODE, STALL_REQUEST, READ_WORD_VALID;
  logic [31:0] WRITE_WORD, READ_WORD;
  logic [7:0] ADDRESS;
  logic [3:0] LANE_ENABLES;
  int errors = 0, compares = 0;
  psr_read_port u_psr_read_port (.*);
  psr_fabric_model fab (.*);
  // Clock and hang guard
  always #2 SYS_CLK = ~SYS_CLK;
  initial begin #4000; errors++; conclude; end
  // Word compare
  task chk(logic [31:0] g, e);
    compares++;
    if (g !== e) begin errors++; $display("[FAIL] %0t got %h want %h", $time, g, e); end
  endtask
  // Count compare
  task chk_cnt(logic [7:0] g, e);
    compares++;
    if (g !== e) begin errors++; $display("[FAIL] %0t count %0d want %0d", $time, g, e); end
  endtask
  // Release bus, drain, compare returns in order
  task rets(logic [31:0] e[$]);
    fab.idle;
    repeat (30) @(negedge SYS_CLK);
    foreach (e[i]) chk(fab.got.size() ? fab.got.pop_front() : 'x, e[i]);
    chk_cnt(8'(fab.got.size()), 8'h0);
  endtask
  // Back-to-back writes, lane merge, fixed reads each cycle
  task t_fixed;
    for (int i = 0; i < 4; i++) fab.req(1, 0, 8'(i), 32'hA0 + i, 4'hF);
    fab.req(1, 0, 8'h0, 32'hFFFFFFFF, 4'h5);
    for (int i = 0; i < 4; i++) fab.req(0, 0, 8'(i), 0, 0);
    rets({32'h00FF00FF, 32'hA1, 32'hA2, 32'hA3});
  endtask
  // Variable reads, stall at four, write amid reads
  task t_var;
    for (int i = 3; i >= 0; i--) fab.req(0, 1, 8'(i), 0, 0);
    fab.req(0, 1, 8'h1, 0, 0);
    fab.req(1, 0, 8'h3, 32'h5, 4'hF);
    fab.req(0, 0, 8'h3, 0, 0);
    rets({32'hA3, 32'hA2, 32'hA1, 32'h00FF00FF, 32'hA1, 32'h5});
  endtask
  // Reset with reads in flight drops them, port serves again after
  task t_rst;
    fab.req(0, 1, 8'h3, 0, 0);
    fab.req(0, 1, 8'h2, 0, 0);
    fab.idle;
    RST = 1;
    repeat (20) @(negedge SYS_CLK);
    RST = 0;
    fab.req(0, 0, 8'h2, 0, 0);
    rets({32'hA2});
  endtask
  // Reset, scenarios, verdict
  initial begin
    repeat (20) @(negedge SYS_CLK);
    RST = 0;
    t_fixed;
    t_var;
    t_rst;
    conclude;
  end
  // Counts and verdict
  task conclude;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
endmodule // psr_read_port_tb_top
`default_nettype wire
